// [inc/ccp_pwm_defs.vh]
// constants for the capture/compare/pwm output block
// assumes a plain register port with byte-wide registers at the offsets below
`ifndef CCP_PWM_DEFS_VH
`define CCP_PWM_DEFS_VH

// ********************************************************************
// register offsets
// ********************************************************************
`define OFS_UNIT1_CONTROL    4'h0
`define OFS_UNIT2_CONTROL    4'h1
`define OFS_DUTY1_LOW        4'h2
`define OFS_DUTY1_HIGH       4'h3
`define OFS_DUTY2_LOW        4'h4
`define OFS_DUTY2_HIGH       4'h5
`define OFS_PERIOD_REGISTER  4'h6
`define OFS_TIMER_CONTROL    4'h7
`define OFS_TIMER_COUNT      4'h8
`define OFS_ALT_PIN_CONTROL  4'h9
`define OFS_PORT_LATCH       4'ha
`define OFS_PIN_DIRECTION    4'hb

// ********************************************************************
// fields
// ********************************************************************
`define CTRL_DUTY_LSB        4
`define CTRL_MODE_MSB        3
`define PWM_MODE_CODE        4'hc
`define TCON_ON_BIT          2
`define PRE_DIV1             2'b00
`define PRE_DIV4             2'b01
`define ALT_UNIT2_SEL_BIT    0

// ********************************************************************
// reset values
// ********************************************************************
`define RST_CONTROL          8'h00
`define RST_ALT_PIN          8'h00
`define RST_PERIOD           8'hff
`define RST_TIMER_CONTROL    8'h00
`define RST_DIRECTION        4'hf

`endif

// [sim/ccp_pwm_checker.sv]
// checker for the pwm output block: reset, sleep, pin mux, pulse spacing
// sees only top ports; mode, alt select and latch are shadowed from writes
`include "ccp_pwm_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module ccp_pwm_checker (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic [7:0] reg_rdata,
    input wire logic       unit1_pin_out,
    input wire logic       unit1_pin_oe,
    input wire logic       unit2_pin_a_out,
    input wire logic       unit2_pin_b_out
);
    // ************
    // shadows and properties
    // ************
    logic       p1_reg, p2_reg, alt_reg;
    logic [2:0] lat_reg;
    wire        m = reg_wdata[3:0] == `PWM_MODE_CODE;
    always_ff @(posedge clk)
        if (reset) {p1_reg, p2_reg, alt_reg, lat_reg} <= 6'h00;
        else if (reg_write && clk_en) case (reg_addr)
            `OFS_UNIT1_CONTROL:   p1_reg <= m;
            `OFS_UNIT2_CONTROL:   p2_reg <= m;
            `OFS_ALT_PIN_CONTROL: alt_reg <= reg_wdata[0];
            `OFS_PORT_LATCH:      lat_reg <= reg_wdata[2:0];
            default: ;
        endcase
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_rst; $fell(reset) |-> !unit1_pin_oe && unit1_pin_out == 1'b0; endproperty
    a_rst: assert property (p_rst) else $error("pin driven after reset");
    property p_slp; !clk_en |=> $stable({unit1_pin_out, unit2_pin_a_out}); endproperty
    a_slp: assert property (p_slp) else $error("pin moved in sleep");
    property p_slr; !clk_en |=> $stable(reg_rdata); endproperty
    a_slr: assert property (p_slr) else $error("read data moved in sleep");
    property p_dir; reg_write && clk_en && reg_addr == `OFS_PIN_DIRECTION
        && !reg_wdata[0] |=> unit1_pin_oe; endproperty
    a_dir: assert property (p_dir) else $error("pin not driven");
    property p_mx1; !p1_reg |-> unit1_pin_out == lat_reg[0]; endproperty
    a_mx1: assert property (p_mx1) else $error("pin1 not latch");
    property p_mxa; !(p2_reg && !alt_reg) |-> unit2_pin_a_out == lat_reg[1]; endproperty
    a_mxa: assert property (p_mxa) else $error("pin2a not latch");
    property p_mxb; !(p2_reg && alt_reg) |-> unit2_pin_b_out == lat_reg[2]; endproperty
    a_mxb: assert property (p_mxb) else $error("pin2b not latch");
    property p_per; p1_reg && $rose(unit1_pin_out) |=> (!$rose(unit1_pin_out)) [*3]; endproperty
    a_per: assert property (p_per) else $error("period too short");
    c_p1: cover property (p1_reg && $rose(unit1_pin_out));
    c_p2: cover property (p2_reg && alt_reg && $rose(unit2_pin_b_out));
    c_sl: cover property (!clk_en && unit1_pin_out);
endmodule
bind ccp_pwm_output ccp_pwm_checker chk (.clk, .reset, .clk_en, .reg_addr, .reg_wdata,
    .reg_write, .reg_rdata, .unit1_pin_out, .unit1_pin_oe, .unit2_pin_a_out, .unit2_pin_b_out);
`default_nettype wire

// [sim/tb_top.sv]
// bench for the pwm output block: registers, pwm timing, buffering, sleep, pin mux
// drives the ports itself; waits are bounded by the cycle ceiling only
`include "ccp_pwm_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // ************
    // design, bus tasks and scenarios
    // ************
    logic       clk = 1'b0, reset = 1'b1, clk_en = 1'b1, reg_write = 1'b0, reg_read = 1'b0, last;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    wire  [7:0] reg_rdata;
    wire        unit1_pin_out, unit1_pin_oe, unit2_pin_a_out, unit2_pin_a_oe;
    wire        unit2_pin_b_out, unit2_pin_b_oe;
    int         failures = 0, n_compared = 0, cycles = 0, h, r;
    ccp_pwm_output dut (.clk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .unit1_pin_out, .unit1_pin_oe, .unit2_pin_a_out, .unit2_pin_a_oe,
        .unit2_pin_b_out, .unit2_pin_b_oe);
    task automatic chk(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic t_regs;
        logic [7:0] v [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'h0f, 8'h00};
        for (int i = 0; i < 13; i++) rd(i[3:0], v[i]);
        chk({unit1_pin_oe, unit2_pin_a_oe, unit2_pin_b_oe}, 3'h0);
        wr(`OFS_UNIT1_CONTROL, 8'hff);
        rd(`OFS_UNIT1_CONTROL, 8'h3f);
        wr(`OFS_UNIT1_CONTROL, 8'h00);
    endtask
    // phase-free: one period window holds the high time and one rising edge, none when duty is zero or oversize
    task automatic t_wave(input logic [7:0] per, input logic [1:0] pre, input logic [9:0] d,
                          input int hi, len);
        wr(`OFS_PERIOD_REGISTER, per);
        wr(`OFS_DUTY1_LOW, d[9:2]);
        wr(`OFS_UNIT1_CONTROL, {2'b00, d[1:0], `PWM_MODE_CODE});
        wr(`OFS_TIMER_CONTROL, {6'h01, pre});
        repeat (2 * len) @(negedge clk);
        h = 0;
        r = 0;
        repeat (len) begin
            last = unit1_pin_out;
            @(negedge clk);
            h += unit1_pin_out;
            r += unit1_pin_out & !last;
        end
        chk(h, hi);
        chk(r, hi > 0 && hi < len);
    endtask
    task automatic high_len;
        h = 0;
        wait (unit1_pin_out === 1'b0);
        wait (unit1_pin_out === 1'b1);
        @(negedge clk);
        while (unit1_pin_out === 1'b1) begin
            h++;
            @(negedge clk);
        end
    endtask
    task automatic t_buffer;
        t_wave(8'h01, 2'b00, 10'h004, 4, 8);
        fork
            high_len;
            begin
                wait (unit1_pin_out === 1'b0);
                wait (unit1_pin_out === 1'b1);
                wr(`OFS_UNIT1_CONTROL, {4'h3, `PWM_MODE_CODE});
            end
        join
        chk(h, 4);
        high_len;
        chk(h, 7);
    endtask
    task automatic t_sleep;
        wait (unit1_pin_out === 1'b1);
        @(posedge clk);
        clk_en <= 1'b0;
        repeat (12) @(negedge clk) chk(unit1_pin_out, 1'b1);
        @(posedge clk);
        clk_en <= 1'b1;
        high_len;
        chk(h, 7);
    endtask
    task automatic t_mux;
        wr(`OFS_PIN_DIRECTION, 8'h00);
        #1 chk({unit1_pin_oe, unit2_pin_a_oe, unit2_pin_b_oe}, 3'h7);
        wr(`OFS_UNIT1_CONTROL, 8'h00);
        wr(`OFS_PORT_LATCH, 8'h05);
        #1 chk({unit1_pin_out, unit2_pin_a_out, unit2_pin_b_out}, 3'h5);
        wr(`OFS_ALT_PIN_CONTROL, 8'h01);
        wr(`OFS_DUTY2_LOW, 8'h01);
        wr(`OFS_UNIT2_CONTROL, {4'h0, `PWM_MODE_CODE});
        repeat (16) @(negedge clk);
        h = 0;
        repeat (8) @(negedge clk) h += unit2_pin_b_out;
        chk(h, 4);
        chk(unit2_pin_a_out, 1'b0);
    endtask
    task automatic stop_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            $display("BAD %0t timeout", $time);
            stop_test;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        t_wave(8'h01, 2'b01, 10'h005, 20, 32);
        t_wave(8'h01, 2'b10, 10'h006, 96, 128);
        t_wave(8'h01, 2'b00, 10'h000, 0, 8);
        t_wave(8'h01, 2'b00, 10'h00c, 8, 8);
        t_buffer;
        t_sleep;
        t_mux;
        t_wave(8'hff, 2'b00, 10'h203, 515, 1024);
        wr(`OFS_DUTY1_HIGH, 8'h55);
        rd(`OFS_DUTY1_HIGH, 8'h80);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        stop_test;
    end
endmodule
`default_nettype wire

// [verilog/ccp_pwm_output.v]
// two-unit pwm output driven by a shared 8-bit period timer with prescaler
// assumes software on a same-clock register port; clk_en low models sleep
// Operation
// - compare logic halts while clock stopped
// - pwm mode drives pin, ten-bit resolution
// - period is (period+1) times 4 times prescale
// - rollover clears timer, sets pin unless duty is zero, loads duty
// - postscaler never affects pwm frequency
// - duty is low byte plus control bits 5:4
// - duty writes take effect next period
// - high duty byte read-only in pwm mode, double buffered
// - time base is timer plus two low bits
// - pin clears when time base equals duty
// - high time equals duty times prescaled clock
// - resolution grows with period register value
// - oversize duty leaves pin unchanged
// - prescaler divides by 1, 4, 16
// - sleep freezes count and pin state
// - zero control releases pin to port
// - pin muxed between pwm and port latch
// - unit two routes to either pin
// - reset restores registers, pins become inputs
// - pwm frequency tracks oscillator frequency
`include "ccp_pwm_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module ccp_pwm_output #(
    parameter TIMER_WIDTH = 8
) (
    input  wire       clk,
    input  wire       reset,
    input  wire       clk_en,
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_write,
    input  wire       reg_read,
    output reg  [7:0] reg_rdata,
    output wire       unit1_pin_out,
    output wire       unit1_pin_oe,
    output wire       unit2_pin_a_out,
    output wire       unit2_pin_a_oe,
    output wire       unit2_pin_b_out,
    output wire       unit2_pin_b_oe
);

    // ****************************************************************
    // software-visible registers
    // ****************************************************************
    reg [7:0] unit1_control_reg;
    reg [7:0] unit2_control_reg;
    reg [7:0] duty1_low_reg;
    reg [7:0] duty2_low_reg;
    reg [7:0] duty1_high_reg;
    reg [7:0] duty2_high_reg;
    reg [1:0] duty1_latch_reg;
    reg [1:0] duty2_latch_reg;
    reg [7:0] period_reg;
    reg [7:0] timer_control_reg;
    reg [7:0] alt_pin_control_reg;
    reg [3:0] port_latch_reg;
    reg [3:0] direction_reg;

    // ****************************************************************
    // time base
    // ****************************************************************
    reg  [TIMER_WIDTH-1:0] timer_reg;
    reg  [3:0]             prescale_reg;
    reg  [1:0]             phase_reg;
    reg                    pwm1_reg;
    reg                    pwm2_reg;

    wire       timer_on = timer_control_reg[`TCON_ON_BIT];
    wire [1:0] pre_sel  = timer_control_reg[1:0];
    // divide 1, 4 or 16 (both upper codes give 16)
    wire [3:0] pre_last = (pre_sel == `PRE_DIV1) ? 4'h0 :
                          (pre_sel == `PRE_DIV4) ? 4'h3 : 4'hf;
    // one clk is one oscillator period; four clk form one prescaler count, so one timer tick at 1:1
    // at-or-past so a smaller prescale picked mid-run never waits for a 4-bit wrap
    wire       pre_done = (prescale_reg >= pre_last);
    wire       tick     = timer_on && (phase_reg == 2'h3) && pre_done;
    wire       rollover = tick && (timer_reg == period_reg);

    // low two bits from clock phase at 1:1, else from prescaler
    wire [1:0] low_bits = (pre_sel == `PRE_DIV1) ? phase_reg :
                          (pre_sel == `PRE_DIV4) ? prescale_reg[1:0] : prescale_reg[3:2];
    wire [9:0] time_base = {timer_reg, low_bits};
    // base steps each clk at 1:1, every 4 clk at 1:4, every 16 clk at 1:16
    wire       base_adv  = timer_on && ((pre_sel == `PRE_DIV1) ||
                           ((phase_reg == 2'h3) &&
                            ((pre_sel == `PRE_DIV4) || (prescale_reg[1:0] == 2'h3))));
    // clear on the edge the base reaches duty, so high time is duty base steps
    wire [9:0] base_next = time_base + 10'h001;

    wire mode1_pwm = (unit1_control_reg[`CTRL_MODE_MSB:0] == `PWM_MODE_CODE);
    wire mode2_pwm = (unit2_control_reg[`CTRL_MODE_MSB:0] == `PWM_MODE_CODE);

    wire [9:0] duty1_new = {duty1_low_reg, unit1_control_reg[`CTRL_DUTY_LSB+1:`CTRL_DUTY_LSB]};
    wire [9:0] duty2_new = {duty2_low_reg, unit2_control_reg[`CTRL_DUTY_LSB+1:`CTRL_DUTY_LSB]};
    wire [9:0] duty1_act = {duty1_high_reg, duty1_latch_reg};
    wire [9:0] duty2_act = {duty2_high_reg, duty2_latch_reg};

    // ****************************************************************
    // register writes and the pwm engine
    // ****************************************************************
    // clk_en low stands for sleep: nothing moves, pins hold
    always @(posedge clk) begin
        if (reset) begin
            unit1_control_reg   <= `RST_CONTROL;
            unit2_control_reg   <= `RST_CONTROL;
            duty1_low_reg       <= 8'h00;
            duty2_low_reg       <= 8'h00;
            duty1_high_reg      <= 8'h00;
            duty2_high_reg      <= 8'h00;
            duty1_latch_reg     <= 2'h0;
            duty2_latch_reg     <= 2'h0;
            period_reg          <= `RST_PERIOD;
            timer_control_reg   <= `RST_TIMER_CONTROL;
            alt_pin_control_reg <= `RST_ALT_PIN;
            port_latch_reg      <= 4'h0;
            direction_reg       <= `RST_DIRECTION;
            timer_reg           <= {TIMER_WIDTH{1'b0}};
            prescale_reg        <= 4'h0;
            phase_reg           <= 2'h0;
            pwm1_reg            <= 1'b0;
            pwm2_reg            <= 1'b0;
        end else if (clk_en) begin
            // postscaler bits 6:3 are stored only, never read here
            if (reg_write) begin
                case (reg_addr)
                    `OFS_UNIT1_CONTROL:   unit1_control_reg   <= {2'b00, reg_wdata[5:0]};
                    `OFS_UNIT2_CONTROL:   unit2_control_reg   <= {2'b00, reg_wdata[5:0]};
                    `OFS_DUTY1_LOW:       duty1_low_reg       <= reg_wdata;
                    `OFS_DUTY2_LOW:       duty2_low_reg       <= reg_wdata;
                    `OFS_DUTY1_HIGH: begin
                        if (!mode1_pwm) duty1_high_reg <= reg_wdata;
                    end
                    `OFS_DUTY2_HIGH: begin
                        if (!mode2_pwm) duty2_high_reg <= reg_wdata;
                    end
                    `OFS_PERIOD_REGISTER: period_reg          <= reg_wdata;
                    `OFS_TIMER_CONTROL:   timer_control_reg   <= {1'b0, reg_wdata[6:0]};
                    `OFS_ALT_PIN_CONTROL: alt_pin_control_reg <= {6'h00, reg_wdata[1:0]};
                    `OFS_PORT_LATCH:      port_latch_reg      <= reg_wdata[3:0];
                    `OFS_PIN_DIRECTION:   direction_reg       <= reg_wdata[3:0];
                    default: ;
                endcase
            end
            if (timer_on) begin
                phase_reg <= phase_reg + 2'h1;
                if (phase_reg == 2'h3)
                    prescale_reg <= pre_done ? 4'h0 : prescale_reg + 4'h1;
            end
            if (tick)
                timer_reg <= rollover ? {TIMER_WIDTH{1'b0}} : timer_reg + 1'b1;
            // writing zero to control drops the waveform latch low
            if (rollover) begin
                duty1_high_reg  <= duty1_new[9:2];
                duty1_latch_reg <= duty1_new[1:0];
                duty2_high_reg  <= duty2_new[9:2];
                duty2_latch_reg <= duty2_new[1:0];
                pwm1_reg        <= mode1_pwm && (duty1_new != 10'h000);
                pwm2_reg        <= mode2_pwm && (duty2_new != 10'h000);
            end else begin
                // match only inside the period; oversize duty never hits
                if (!mode1_pwm || (base_adv && base_next == duty1_act))
                    pwm1_reg <= 1'b0;
                if (!mode2_pwm || (base_adv && base_next == duty2_act))
                    pwm2_reg <= 1'b0;
            end
        end
    end
    // resolution follows period_reg since the match spans {timer,2 bits}

    // ****************************************************************
    // pin muxing
    // ****************************************************************
    // pin bits: 0 unit1, 1 unit2 pin a, 2 unit2 pin b
    wire unit2_on_b = alt_pin_control_reg[`ALT_UNIT2_SEL_BIT];
    // pwm owns the pin only in pwm mode; else the port latch
    assign unit1_pin_out   = mode1_pwm ? pwm1_reg : port_latch_reg[0];
    assign unit2_pin_a_out = (mode2_pwm && !unit2_on_b) ? pwm2_reg : port_latch_reg[1];
    assign unit2_pin_b_out = (mode2_pwm && unit2_on_b) ? pwm2_reg : port_latch_reg[2];
    // direction bit clear means drive; software must clear it
    assign unit1_pin_oe    = ~direction_reg[0];
    assign unit2_pin_a_oe  = ~direction_reg[1];
    assign unit2_pin_b_oe  = ~direction_reg[2];

    // ****************************************************************
    // read path, data one cycle after the strobe
    // ****************************************************************
    always @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read && clk_en) begin
            case (reg_addr)
                `OFS_UNIT1_CONTROL:   reg_rdata <= unit1_control_reg;
                `OFS_UNIT2_CONTROL:   reg_rdata <= unit2_control_reg;
                `OFS_DUTY1_LOW:       reg_rdata <= duty1_low_reg;
                `OFS_DUTY2_LOW:       reg_rdata <= duty2_low_reg;
                `OFS_DUTY1_HIGH:      reg_rdata <= duty1_high_reg;
                `OFS_DUTY2_HIGH:      reg_rdata <= duty2_high_reg;
                `OFS_PERIOD_REGISTER: reg_rdata <= period_reg;
                `OFS_TIMER_CONTROL:   reg_rdata <= timer_control_reg;
                `OFS_TIMER_COUNT:     reg_rdata <= timer_reg;
                `OFS_ALT_PIN_CONTROL: reg_rdata <= alt_pin_control_reg;
                `OFS_PORT_LATCH:      reg_rdata <= {4'h0, port_latch_reg};
                `OFS_PIN_DIRECTION:   reg_rdata <= {4'h0, direction_reg};
                default:              reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

`default_nettype wire
